/* File: rtl/range_limits.sv */
/*
 * Registered lookup of the high and low signal limits of one analog input.
 * Assumes the range code is held steady; limits follow one cycle later.
 */
`default_nettype none

module range_limits
	import redundancy_pkg::*;
(
	input  wire logic                                   clk_i,
	input  wire logic                                   rst_i,
	input  wire logic                                   ce_i,
	input  wire redundancy_pkg::range_t                 range_i,
	output logic signed [redundancy_pkg::AI_WIDTH-1:0]  high_o,
	output logic signed [redundancy_pkg::AI_WIDTH-1:0]  low_o
);

	typedef struct packed {
		logic signed [AI_WIDTH-1:0] high;
		logic signed [AI_WIDTH-1:0] low;
	} lim_state_t;

	lim_state_t s;
	lim_state_t next_s;

	// ==========================================================================
	// Limit selection
	// ==========================================================================
	// Picks the limit pair of the selected range; an unknown code gets the widest pair.
	always_comb begin
		next_s = s;
		case (range_i)
			RANGE_4_20MA: begin
				next_s.high = LIM_4_20_HI;
				next_s.low  = LIM_4_20_LO;
			end
			RANGE_0_20MA: begin
				next_s.high = LIM_20MA_HI;
				next_s.low  = LIM_0_20_LO;
			end
			RANGE_PM20MA: begin
				next_s.high = LIM_20MA_HI;
				next_s.low  = LIM_PM20_LO;
			end
			RANGE_PM30MA: begin
				next_s.high = LIM_30MA_HI;
				next_s.low  = LIM_30MA_LO;
			end
			RANGE_0_10V: begin
				next_s.high = LIM_10V_HI;
				next_s.low  = LIM_0_10V_LO;
			end
			RANGE_PM10V: begin
				next_s.high = LIM_10V_HI;
				next_s.low  = LIM_PM10V_LO;
			end
			default: begin
				next_s.high = LIM_30MA_HI;
				next_s.low  = LIM_30MA_LO;
			end
		endcase
	end

	// Registers the pair; reset gives the 4 to 20 mA limits.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s.high <= LIM_4_20_HI;
			s.low  <= LIM_4_20_LO;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	assign high_o = s.high;
	assign low_o  = s.low;

endmodule : range_limits

`default_nettype wire

/* File: rtl/redundancy_master_selection.sv */
/*
 * Redundancy manager: master/reserve role by error weight, fieldbus interface
 * selection, output gating and a classic Wishbone register slave.
 * Assumes all inputs synchronous to clk_i and a partner running the same logic.
 */
// The Wishbone interface to the registers and the address map were decided locally.
// Behaviour
// - Master stays active until its own faults make it hand over; it also leaves on equal weight without preset, or on link loss unless forced.
// - Handover decision uses weighted sum of all detected errors.
// - Memory faults weigh more than all channel errors together.
// - Channel errors come from 12 analog inputs, 8 analog outputs, 16 digital outputs.
// - Every monitored channel adds the same weighting factor.
// - 4 to 20 mA inputs flag errors above 22.96 mA or below 1.185 mA.
// - Other input ranges use their own high and low limits.
// - Analog output mismatch flagged, except while commanded value is zero.
// - Digital output driven high but read back low is a short to ground.
// - DP error, bad sign of life or global clear switches fieldbus interface.
// - Parameter command switches interface; redundancy status is readable.
// - Input data go in parallel to both fieldbus interfaces.
// - Outputs follow one host only; passive host data only compared.
// - Host role swap switches which host data drives outputs.
// - Silent active interface gives way to the working one.
// - Both interfaces silent: outputs forced to zero.
// - Host command names the active interface and is adopted.
// - Reserve runs in step but keeps process outputs passive.
// - Loss shuts outputs after tolerance time, 10 ms to 3 s, default 0.5 s.
`default_nettype none

module redundancy_master_selection
	import redundancy_pkg::*;
#(
	parameter int MS_CYCLES = redundancy_pkg::MS_CYCLES_DEF
) (
	input  wire logic                                                   clk_i,
	input  wire logic                                                   rst_i,
	input  wire logic                                                   ce_i,
	input  wire logic                                                   cyc_i,
	input  wire logic                                                   stb_i,
	input  wire logic                                                   we_i,
	input  wire logic [7:0]                                             adr_i,
	input  wire logic [3:0]                                             sel_i,
	input  wire logic [31:0]                                            dat_i,
	output logic [31:0]                                                 dat_o,
	output logic                                                        ack_o,
	input  wire logic                                                   mem_fault_i,
	input  wire logic [AI_CHANNELS-1:0][AI_WIDTH-1:0]                   ai_value_i,
	input  wire redundancy_pkg::range_t [AI_CHANNELS-1:0]               ai_range_i,
	input  wire logic [AO_CHANNELS-1:0][AO_WIDTH-1:0]                   ao_request_i,
	input  wire logic [AO_CHANNELS-1:0][AO_WIDTH-1:0]                   ao_readback_i,
	input  wire logic [DO_CHANNELS-1:0]                                 do_readback_i,
	output logic [DO_CHANNELS-1:0]                                      do_out_o,
	output logic                                                        outputs_enable_o,
	input  wire logic                                                   link_ok_i,
	input  wire logic [WEIGHT_W-1:0]                                    partner_weight_i,
	input  wire logic                                                   partner_active_i,
	output logic [WEIGHT_W-1:0]                                         weight_o,
	output logic                                                        active_o,
	input  wire logic [1:0]                                             frame_i,
	input  wire logic [1:0][7:0]                                        life_i,
	input  wire logic [1:0]                                             bus_error_i,
	input  wire logic [1:0]                                             global_clear_i,
	input  wire logic                                                   prm_cmd_i,
	input  wire logic                                                   prm_second_i,
	input  wire logic [DO_CHANNELS-1:0]                                 out_first_i,
	input  wire logic [DO_CHANNELS-1:0]                                 out_second_i,
	input  wire logic [IN_WIDTH-1:0]                                    in_data_i,
	output logic [IN_WIDTH-1:0]                                         in_first_o,
	output logic [IN_WIDTH-1:0]                                         in_second_o,
	output logic                                                        active_second_o
);

	typedef struct packed {
		role_t                  role;
		logic                   active_second;
		logic [WEIGHT_W-1:0]    weight;
		logic [AI_CHANNELS-1:0] ai_err;
		logic [AO_CHANNELS-1:0] ao_err;
		logic [DO_CHANNELS-1:0] do_err;
		logic [DO_CHANNELS-1:0] do_out;
		logic [IN_WIDTH-1:0]    in_first;
		logic [IN_WIDTH-1:0]    in_second;
		logic [1:0][7:0]        life_last;
		logic [TICK_W-1:0]      tick;
		logic [1:0][TOL_W-1:0]  silence;
		logic                   preset;
		logic                   forced;
		logic [TOL_W-1:0]       tol_ms;
		logic                   passive_diff;
		logic                   ack;
		logic [31:0]            dat;
	} state_t;

	state_t s;
	state_t next_s;

	logic signed [AI_WIDTH-1:0] lim_high [AI_CHANNELS];
	logic signed [AI_WIDTH-1:0] lim_low  [AI_CHANNELS];

	// ==========================================================================
	// Analog input limits
	// ==========================================================================
	// One limit lookup per analog input channel.
	for (genvar g = 0; g < AI_CHANNELS; g++) begin : g_limits
		range_limits u_limits (
			.clk_i   (clk_i),
			.rst_i   (rst_i),
			.ce_i    (ce_i),
			.range_i (ai_range_i[g]),
			.high_o  (lim_high[g]),
			.low_o   (lim_low[g])
		);
	end

	// ==========================================================================
	// Next-state logic
	// ==========================================================================
	logic                  bus_write;
	logic                  cmd_valid;
	logic                  cmd_second;
	logic [1:0]            alive;
	logic                  safe_zero;
	logic                  want_master;
	logic                  leave_master;
	logic                  enabled_next;
	logic [1:0]            life_bad;
	logic [WEIGHT_W-1:0]   err_count;
	logic [31:0]           wmask;
	logic [31:0]           ctl_word;
	logic [TOL_W-1:0]      tol_req;

	// Computes every register's next value from the current state and inputs.
	always_comb begin
		next_s     = s;
		err_count  = '0;
		wmask      = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
		ctl_word   = (dat_i & wmask) | ({28'h0000000, 1'b0, s.active_second, s.forced, s.preset} & ~wmask);
		tol_req    = dat_i[TOL_W-1:0];
		bus_write  = cyc_i && stb_i && we_i && s.ack;

		// Channel monitors; each error bit counts the same.
		for (int i = 0; i < AI_CHANNELS; i++) begin
			next_s.ai_err[i] = ($signed(ai_value_i[i]) > lim_high[i])
			                   || ($signed(ai_value_i[i]) < lim_low[i]);
		end
		for (int i = 0; i < AO_CHANNELS; i++) begin
			next_s.ao_err[i] = (ao_request_i[i] != '0) && (ao_request_i[i] != ao_readback_i[i]);
		end
		next_s.do_err = s.do_out & ~do_readback_i;
		for (int i = 0; i < AI_CHANNELS; i++) begin
			err_count = err_count + {7'h00, s.ai_err[i]};
		end
		for (int i = 0; i < AO_CHANNELS; i++) begin
			err_count = err_count + {7'h00, s.ao_err[i]};
		end
		for (int i = 0; i < DO_CHANNELS; i++) begin
			err_count = err_count + {7'h00, s.do_err[i]};
		end
		// Memory fault outweighs all channels put together.
		next_s.weight = (mem_fault_i ? WEIGHT_MEMORY : '0) + WEIGHT_CHANNEL * err_count;

		// Millisecond prescaler and per-interface silence counters.
		next_s.tick = (s.tick == TICK_W'(MS_CYCLES - 1)) ? '0 : s.tick + 1'b1;
		for (int k = 0; k < 2; k++) begin
			if (frame_i[k]) begin
				next_s.silence[k] = '0;
			end else if (s.tick == TICK_W'(MS_CYCLES - 1) && s.silence[k] != TOL_MAX_MS) begin
				next_s.silence[k] = s.silence[k] + 1'b1;
			end
			alive[k]    = s.silence[k] < s.tol_ms;
			life_bad[k] = frame_i[k] && (life_i[k] != s.life_last[k] + 8'h01);
			if (frame_i[k]) begin
				next_s.life_last[k] = life_i[k];
			end
		end
		safe_zero = !alive[0] && !alive[1];

		// Interface selection: explicit command first, then loss, then events.
		cmd_valid  = (bus_write && adr_i[7:2] == REG_CONTROL[7:2] && sel_i[0] && dat_i[CTL_CMD_BIT]) || prm_cmd_i;
		cmd_second = prm_cmd_i ? prm_second_i : dat_i[CTL_SECOND_BIT];
		if (cmd_valid) begin
			next_s.active_second = cmd_second;
		end else if (!alive[s.active_second] && alive[!s.active_second]) begin
			next_s.active_second = !s.active_second;
		end else if (bus_error_i[s.active_second] || life_bad[s.active_second] || global_clear_i[s.active_second]) begin
			next_s.active_second = !s.active_second;
		end

		// Role decision from exchanged weights, or host force without link.
		want_master  = (s.weight < partner_weight_i) || (s.weight == partner_weight_i && s.preset);
		leave_master = link_ok_i ? ((s.weight > partner_weight_i) || (s.weight == partner_weight_i && !s.preset))
		                         : !s.forced;
		case (s.role)
			ROLE_RESERVE: begin
				if (link_ok_i ? (want_master && !partner_active_i) : s.forced) begin
					next_s.role = ROLE_MASTER;
				end
			end
			ROLE_MASTER: begin
				if (leave_master) begin
					next_s.role = ROLE_RELEASE;
				end
			end
			ROLE_RELEASE: begin
				next_s.role = ROLE_RESERVE;
			end
			default: begin
				next_s.role = ROLE_RESERVE;
			end
		endcase

		// Only the active host's data reach the pins; reserve stays passive.
		enabled_next  = (next_s.role == ROLE_MASTER) && !safe_zero;
		next_s.do_out = enabled_next ? (next_s.active_second ? out_second_i : out_first_i) : '0;
		next_s.in_first  = in_data_i;
		next_s.in_second = in_data_i;

		// Passive host data compared for monitoring, then dropped; set beats clear.
		if (bus_write && adr_i[7:2] == REG_STATUS[7:2] && sel_i[0] && dat_i[ST_DIFF_BIT]) begin
			next_s.passive_diff = 1'b0;
		end
		if (alive[0] && alive[1] && out_first_i != out_second_i) begin
			next_s.passive_diff = 1'b1;
		end

		// Wishbone slave: ack one cycle after the strobe, write on the acked edge.
		next_s.ack = cyc_i && stb_i && !s.ack;
		if (bus_write && adr_i[7:2] == REG_CONTROL[7:2]) begin
			next_s.preset = ctl_word[CTL_PRESET_BIT];
			next_s.forced = ctl_word[CTL_FORCED_BIT];
		end
		if (bus_write && adr_i[7:2] == REG_TOLERANCE[7:2] && sel_i[1:0] == 2'b11) begin
			next_s.tol_ms = (tol_req < TOL_MIN_MS) ? TOL_MIN_MS : (tol_req > TOL_MAX_MS) ? TOL_MAX_MS : tol_req;
		end
		case ({adr_i[7:2], 2'b00})
			REG_CONTROL:   next_s.dat = {28'h0000000, 1'b0, s.active_second, s.forced, s.preset};
			REG_TOLERANCE: next_s.dat = {20'h00000, s.tol_ms};
			REG_STATUS:    next_s.dat = {8'h00, partner_weight_i, s.weight, 2'b00, s.passive_diff, link_ok_i,
			                             safe_zero, s.active_second, outputs_enable_o, active_o};
			REG_CHAN_ERR:  next_s.dat = {12'h000, s.ao_err, s.ai_err};
			REG_DO_ERR:    next_s.dat = {16'h0000, s.do_err};
			default:       next_s.dat = 32'h00000000;
		endcase
		if (!(cyc_i && stb_i && !s.ack)) begin
			next_s.dat = s.dat;
		end
	end

	// Registers the whole state; reset starts as reserve on the first interface.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s        <= '0;
			s.role   <= ROLE_RESERVE;
			s.tol_ms <= TOL_DEFAULT_MS;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	// ==========================================================================
	// Outputs
	// ==========================================================================
	// Drives ports from the state register; outputs_enable_o and active_o are decoded from it.
	assign dat_o            = s.dat;
	assign ack_o            = s.ack;
	assign do_out_o         = s.do_out;
	assign outputs_enable_o = (s.role == ROLE_MASTER) && !safe_zero;
	assign weight_o         = s.weight;
	assign active_o         = s.role == ROLE_MASTER;
	assign in_first_o       = s.in_first;
	assign in_second_o      = s.in_second;
	assign active_second_o  = s.active_second;

	// ==========================================================================
	// Assertions
	// ==========================================================================
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_SAFE_ZERO: assert property (ce_i && safe_zero |=> do_out_o == '0)
		else $error("outputs not zero with both interfaces silent");
	AST_NO_OVERLAP: assert property ($rose(active_o) && $past(link_ok_i) |-> !$past(partner_active_i))
		else $error("took master while partner still active");
	AST_HANDOVER: assert property (ce_i && active_o && link_ok_i && weight_o > partner_weight_i |=> !active_o)
		else $error("master with higher weight kept its role");
	AST_MEM_WEIGHT: assert property (ce_i && mem_fault_i |=> weight_o >= WEIGHT_MEMORY)
		else $error("memory fault not weighted");
	AST_DO_SHORT: assert property (ce_i && |(do_out_o & ~do_readback_i) |=> |s.do_err)
		else $error("digital output short not flagged");
	AST_AO_ZERO: assert property (ce_i && ao_request_i[0] == '0 |=> !s.ao_err[0])
		else $error("analog output error flagged at zero command");
	AST_BUS_CMD: assert property (ce_i && prm_cmd_i |=> active_second_o == $past(prm_second_i))
		else $error("interface command not adopted");
	AST_OUT_SELECT: assert property (ce_i && enabled_next && !next_s.active_second |=> do_out_o == $past(out_first_i))
		else $error("outputs not taken from first interface host");
	AST_INPUT_FAN: assert property (ce_i |=> in_first_o == $past(in_data_i) && in_second_o == $past(in_data_i))
		else $error("input data not sent to both interfaces");
	AST_RESERVE_PASSIVE: assert property (!active_o |-> do_out_o == '0)
		else $error("reserve drives process outputs");

endmodule : redundancy_master_selection

`default_nettype wire

/* File: rtl/redundancy_pkg.sv */
/*
 * Shared constants for the redundancy manager: register map, control bits,
 * signal limits, error weights and timing.
 * Assumes a 200 MHz system clock and analog readings in uA or mV.
 */
`default_nettype none

package redundancy_pkg;

	// ==========================================================================
	// Channel counts and widths
	// ==========================================================================
	localparam int AI_CHANNELS = 12;
	localparam int AO_CHANNELS = 8;
	localparam int DO_CHANNELS = 16;
	localparam int AI_WIDTH    = 18;
	localparam int AO_WIDTH    = 16;
	localparam int IN_WIDTH    = 32;
	localparam int WEIGHT_W    = 8;

	// ==========================================================================
	// Analog input ranges and limits (uA for current, mV for voltage)
	// ==========================================================================
	typedef enum logic [2:0] {
		RANGE_4_20MA,
		RANGE_0_20MA,
		RANGE_PM20MA,
		RANGE_PM30MA,
		RANGE_0_10V,
		RANGE_PM10V
	} range_t;

	localparam logic signed [AI_WIDTH-1:0] LIM_4_20_HI  = 18'sh059b0;
	localparam logic signed [AI_WIDTH-1:0] LIM_4_20_LO  = 18'sh004a1;
	localparam logic signed [AI_WIDTH-1:0] LIM_20MA_HI  = 18'sh05c94;
	localparam logic signed [AI_WIDTH-1:0] LIM_0_20_LO  = -18'sh00db7;
	localparam logic signed [AI_WIDTH-1:0] LIM_PM20_LO  = -18'sh05c94;
	localparam logic signed [AI_WIDTH-1:0] LIM_30MA_HI  = 18'sh08ade;
	localparam logic signed [AI_WIDTH-1:0] LIM_30MA_LO  = -18'sh08ade;
	localparam logic signed [AI_WIDTH-1:0] LIM_10V_HI   = 18'sh02e4a;
	localparam logic signed [AI_WIDTH-1:0] LIM_0_10V_LO = -18'sh006e0;
	localparam logic signed [AI_WIDTH-1:0] LIM_PM10V_LO = -18'sh02e4a;

	// ==========================================================================
	// Error weights
	// ==========================================================================
	localparam logic [WEIGHT_W-1:0] WEIGHT_MEMORY  = 8'h40;
	localparam logic [WEIGHT_W-1:0] WEIGHT_CHANNEL = 8'h01;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int CLK_PERIOD_NS = 5;
	localparam int NS_PER_MS     = 1000000;
	localparam int MS_CYCLES_DEF = NS_PER_MS / CLK_PERIOD_NS;
	localparam int TICK_W        = 18;
	localparam int TOL_W         = 12;
	localparam logic [TOL_W-1:0] TOL_DEFAULT_MS = 12'h1f4;
	localparam logic [TOL_W-1:0] TOL_MIN_MS     = 12'h00a;
	localparam logic [TOL_W-1:0] TOL_MAX_MS     = 12'hbb8;

	// ==========================================================================
	// Register map (byte addresses) and control bits
	// ==========================================================================
	localparam logic [7:0] REG_CONTROL   = 8'h00;
	localparam logic [7:0] REG_TOLERANCE = 8'h04;
	localparam logic [7:0] REG_STATUS    = 8'h08;
	localparam logic [7:0] REG_CHAN_ERR  = 8'h0c;
	localparam logic [7:0] REG_DO_ERR    = 8'h10;

	localparam int CTL_PRESET_BIT = 0;
	localparam int CTL_FORCED_BIT = 1;
	localparam int CTL_SECOND_BIT = 2;
	localparam int CTL_CMD_BIT    = 3;
	localparam int ST_DIFF_BIT    = 5;

	typedef enum logic [1:0] {
		ROLE_RESERVE,
		ROLE_MASTER,
		ROLE_RELEASE
	} role_t;

endpackage : redundancy_pkg

`default_nettype wire

/* File: verification/partner_module_model.sv */
/*
 * Behavioural model of the partner module on the redundancy link.
 * Assumes the bench sets the partner's own error weight directly.
 */
`default_nettype none

module partner_module_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       link_en_i,
	input  wire logic       peer_active_i,
	input  wire logic [7:0] peer_weight_i,
	input  wire logic [7:0] weight_i,
	output logic            link_ok_o,
	output logic [7:0]      weight_o,
	output logic            active_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================
	// Role by weight comparison
	// ==========================================
	// Weight is offered every cycle; takeover waits for the peer to let go.
	assign link_ok_o = ~rst_i & link_en_i;
	assign weight_o  = weight_i;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			active_o <= 1'b0;
		else if (active_o && weight_i > peer_weight_i)
			active_o <= 1'b0;
		else if (!active_o && !peer_active_i && weight_i < peer_weight_i)
			active_o <= 1'b1;
	end
endmodule : partner_module_model

`default_nettype wire

/* File: verification/test_redundancy_master_selection.sv */
/*
 * Self-checking bench: Wishbone tasks, frame source, partner model.
 * Assumes MS_CYCLES of 10, so the 10 ms tolerance is 100 cycles.
 */
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end

module test_redundancy_master_selection;
	timeunit 1ns;
	timeprecision 1ps;
	import redundancy_pkg::*;

	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, mem_fault_i = 1'b0;
	logic [7:0] adr_i = 8'h00, pw, peer_weight = 8'h00, tick = 8'h00;
	logic [31:0] dat_i = 32'h0, dat_o, rd, in_data_i = 32'h5a5a0f0f, in_first_o, in_second_o;
	logic [AI_CHANNELS-1:0][AI_WIDTH-1:0] ai_value_i;
	range_t [AI_CHANNELS-1:0] ai_range_i;
	logic [AO_CHANNELS-1:0][AO_WIDTH-1:0] ao_request_i = '0, ao_readback_i = '0;
	logic [15:0] do_out_o, do_readback_i = 16'h00ff, out_first_i = 16'h00ff, out_second_i = 16'h00a5;
	logic outputs_enable_o, link_ok, pact, active_o, active_second_o, prm_cmd_i = 1'b0, link_en = 1'b1;
	logic [1:0] frame_i = 2'b00, frame_en = 2'b00, bus_error_i = 2'b00, global_clear_i = 2'b00;
	logic [1:0][7:0] life_i = '0;
	logic [7:0] weight_o;
	int fail_count = 0, num_checks = 0;

	initial forever #2.5 clk_i = ~clk_i;

	redundancy_master_selection #(.MS_CYCLES(10)) DUT (.clk_i, .rst_i, .ce_i(1'b1), .cyc_i, .stb_i, .we_i,
		.adr_i, .sel_i(4'hf), .dat_i, .dat_o, .ack_o, .mem_fault_i, .ai_value_i, .ai_range_i, .ao_request_i,
		.ao_readback_i, .do_readback_i, .do_out_o, .outputs_enable_o, .link_ok_i(link_ok), .partner_weight_i(pw),
		.partner_active_i(pact), .weight_o, .active_o, .frame_i, .life_i, .bus_error_i, .global_clear_i,
		.prm_cmd_i, .prm_second_i(1'b0), .out_first_i, .out_second_i, .in_data_i, .in_first_o, .in_second_o,
		.active_second_o);

	// The peer shares every process signal with the block, so only its weight and role are modelled.
	partner_module_model PEER (.clk_i, .rst_i, .link_en_i(link_en), .peer_active_i(active_o), .peer_weight_i(weight_o),
		.weight_i(peer_weight), .link_ok_o(link_ok), .weight_o(pw), .active_o(pact));

	// Frames every 20 cycles on enabled interfaces, sign of life counting up.
	always @(posedge clk_i) begin
		frame_i <= (tick == 8'h13) ? frame_en : 2'b00;
		tick <= (tick == 8'h13) ? 8'h00 : tick + 8'h01;
		if (tick == 8'h13) begin
			for (int k = 0; k < 2; k++)
				if (frame_en[k]) life_i[k] <= life_i[k] + 8'h01;
		end
	end

	// One classic cycle; request held until ack is sampled high.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 16);
		rd = dat_o;
		if (n >= 16) fail_count++;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb

	task automatic settle;
		repeat (10) @(posedge clk_i);
	endtask : settle

	task automatic conclude;
		if (fail_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude

	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		conclude();
	end

	// Main sequence.
	initial begin
		for (int k = 0; k < AI_CHANNELS; k++) begin
			ai_range_i[k] = RANGE_4_20MA;
			ai_value_i[k] = 18'h02ee0;
		end
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		frame_en <= 2'b11;
		wb(1'b0, REG_TOLERANCE, 32'h0);
		`CHK("tol_reset", 32'h000001f4, rd)
		wb(1'b1, REG_TOLERANCE, 32'h00000003);
		wb(1'b0, REG_TOLERANCE, 32'h0);
		`CHK("tol_clamp", 32'h0000000a, rd)
		wb(1'b0, 8'h20, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		wb(1'b1, REG_CONTROL, 32'h00000001);
		settle();
		`CHK("preset_master", 1'b1, active_o)
		`CHK("out_first", out_first_i, do_out_o)
		`CHK("enable_on", 1'b1, outputs_enable_o)
		`CHK("in_second", in_data_i, in_second_o)
		peer_weight <= 8'h05;
		do_readback_i <= 16'h00fe;
		ai_value_i[0] <= 18'h059b1;
		ai_value_i[2] <= 18'h004a0;
		ai_value_i[3] <= 18'h059b0;
		ai_range_i[1] <= RANGE_0_10V;
		ai_value_i[1] <= -18'sh006e1;
		ao_request_i[0] <= 16'h0005;
		ao_readback_i[0] <= 16'h0004;
		settle();
		`CHK("weight_sum", 8'h05, weight_o)
		`CHK("equal_keeps", 1'b1, active_o)
		wb(1'b0, REG_CHAN_ERR, 32'h0);
		`CHK("chan_err", 32'h00001007, rd)
		wb(1'b0, REG_DO_ERR, 32'h0);
		`CHK("do_err", 32'h00000001, rd)
		mem_fault_i <= 1'b1;
		settle();
		`CHK("handover", 1'b0, active_o)
		`CHK("reserve_off", 1'b0, outputs_enable_o)
		`CHK("mem_weight", 8'h44, weight_o)
		mem_fault_i <= 1'b0;
		ai_value_i[1] <= 18'h00100;
		ai_value_i[0] <= 18'h02ee0;
		ai_value_i[2] <= 18'h02ee0;
		ao_readback_i[0] <= 16'h0005;
		settle();
		`CHK("take_back", 1'b1, active_o)
		bus_error_i <= 2'b01;
		@(posedge clk_i);
		bus_error_i <= 2'b00;
		settle();
		`CHK("err_swap", 1'b1, active_second_o)
		`CHK("out_second", out_second_i, do_out_o)
		prm_cmd_i <= 1'b1;
		@(posedge clk_i);
		prm_cmd_i <= 1'b0;
		settle();
		`CHK("prm_first", 1'b0, active_second_o)
		wb(1'b1, REG_CONTROL, 32'h0000000d);
		wb(1'b0, REG_STATUS, 32'h0);
		`CHK("cmd_second", 1'b1, rd[2])
		`CHK("passive_diff", 1'b1, rd[5])
		global_clear_i <= 2'b10;
		@(posedge clk_i);
		global_clear_i <= 2'b00;
		settle();
		`CHK("clear_swap", 1'b0, active_second_o)
		frame_en <= 2'b10;
		repeat (150) @(posedge clk_i);
		`CHK("loss_swap", 1'b1, active_second_o)
		frame_en <= 2'b00;
		repeat (150) @(posedge clk_i);
		`CHK("safe_zero", 16'h0000, do_out_o)
		link_en <= 1'b0;
		wb(1'b0, REG_STATUS, 32'h0);
		`CHK("rating", 16'h0500, rd[23:8])
		`CHK("forced_off", 1'b0, active_o)
		wb(1'b1, REG_CONTROL, 32'h00000003);
		settle();
		`CHK("forced_on", 1'b1, active_o)
		`CHK("enable_off", 1'b0, outputs_enable_o)
		conclude();
	end
endmodule : test_redundancy_master_selection

`default_nettype wire
